// [rtl/cbh_defines.svh]
// Offsets, field positions, reset values and fixed codes of the bridge config header slice.
// Assumes byte offsets into one function's 256-byte configuration space.
`ifndef CBH_DEFINES_SVH
`define CBH_DEFINES_SVH
`define CBH_OFS_LAT 8'h0d
`define CBH_OFS_HDR 8'h0e
`define CBH_OFS_SELFTEST 8'h0f
`define CBH_OFS_BASE 8'h10
`define CBH_OFS_CAP 8'h14
`define CBH_OFS_STAT 8'h16
`define CBH_EXT_START 8'h80
`define CBH_RST_LAT 8'h00
`define CBH_HDR_CODE 8'h82
`define CBH_SELFTEST_CODE 8'h00
`define CBH_RST_BASE 32'h0000_0000
`define CBH_BASE_MASK 32'hffff_f000
`define CBH_CAP_CODE 8'ha0
`define CBH_RST_STAT 16'h0200
`define CBH_STAT_CLR_MASK 16'hf900
`define CBH_STAT_RO_VALUE 16'h0200
`define CBH_WIN_LEGACY 12'h800
`define CBH_BIT_PARITY 15
`define CBH_BIT_SERR 14
`define CBH_BIT_MABORT 13
`define CBH_BIT_TABORT_RX 12
`define CBH_BIT_TABORT_TX 11
`define CBH_BIT_DPAR 8
`endif

// [rtl/cbh_pkg.sv]
// Types shared by the config header slice: card-side event group and window decode.
// Assumes nothing beyond the defines header.
package cbh_pkg;
  typedef struct packed {
    logic parityErr;
    logic systemErr;
    logic masterAbort;
    logic targetAbortRx;
    logic targetAbortTx;
    logic dataParity;
    logic wasMaster;
  } cbh_events_s;

  typedef enum logic [1:0] {
    CBH_WIN_NONE = 2'b00,
    CBH_WIN_SOCKET = 2'b01,
    CBH_WIN_LEGACY = 2'b10
  } cbh_win_e;

  typedef enum logic [0:0] {
    CBH_LT_IDLE = 1'b0,
    CBH_LT_RUN = 1'b1
  } cbh_lt_e;
endpackage : cbh_pkg

// [rtl/cbh_config_header.sv]
// Config header slice (0Dh..17h) of one bridge function: latency timer, fixed codes,
// socket window base and card-side status. Assumes config write/read strobes on the
// PCI clock and card events already synchronous to it.
// Every output is registered; read data lands one cycle after the read strobe.
// One function only: a two-function part places this slice once per function.
// Notes on behaviour
// - Latency count starts at zero on FRAME
// - Expired count ends tenure once GNT drops
// - Latency byte at 0Dh, RW, resets 00h
// - Header type reads 82h, writes ignored
// - 00h-7Fh standard header, 80h-FFh extension
// - Self-test byte reads 00h always
// - Base bits 31-12 writable, 4K aligned
// - Base bits 11-0 read zero
// - All-ones write reads back FFFFF000h
// - Window: sockets at 000h, legacy 800h
// - Base per function, resets to zero
// - Capability pointer reads A0h
// - Status flags clear on write one
// - Status resets 0200h, clearable bits 15-11,8
// - Card events set status bits 15-11
// - Bits 10-9 hardwired 01b
// - Bit 8 needs CPERR, master, enable
`timescale 1ns/1ps
`include "cbh_defines.svh"
module cbh_config_header (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [31:0] cfgWdata,
  input wire logic [3:0] cfgByteEn,
  output logic [31:0] cfgRdata,
  output logic cfgExtSelect,
  input wire logic memValid,
  input wire logic [31:0] memAddr,
  output cbh_pkg::cbh_win_e memWindow,
  output logic [11:0] memWinOffset,
  input wire logic frameStart,
  input wire logic tenureEnd,
  input wire logic gntIn_n,
  output logic latencyStop,
  input wire logic parityResponseEn,
  input wire cbh_pkg::cbh_events_s cardEvents,
  output logic [31:0] socketWindowBase,
  output logic [7:0] masterLatencyCount
);
  import cbh_pkg::*;

  // Writable storage of this function
  logic [31:0] baseReg, next_baseReg;
  logic [7:0] latReg, next_latReg;
  logic [15:0] statReg, next_statReg;

  // Latency timer state and its registered stop request
  logic [7:0] latCnt, next_latCnt;
  cbh_lt_e ltState, next_ltState;
  logic latencyStopQ, next_latencyStop;

  // Registered answers of the config read and the window decode
  logic [31:0] rdataQ, next_rdata;
  logic extQ, next_ext;
  cbh_win_e winQ, next_win;
  logic [11:0] winOfsQ, next_winOfs;

  // Per-cycle set and clear vectors of the card-side status
  logic [15:0] setBits;
  logic [15:0] clrBits;

  // Byte lane merge for a word written to a dword-aligned register
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
                                             input logic [31:0] newV,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = oldV;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  // True when the access hits the dword holding the given byte offset
  function automatic logic hitsDword(input logic [7:0] addr, input logic [7:0] ofs);
    return addr[7:2] == ofs[7:2];
  endfunction : hitsDword

  // Count has reached the programmed limit
  function automatic logic latencyExpired(input logic [7:0] cnt, input logic [7:0] lim);
    return cnt == lim;
  endfunction : latencyExpired

  // Status half of a write to dword 14h: byte lanes 2 and 3 carry bits 15..0
  function automatic logic [15:0] statusLanes(input logic [31:0] data, input logic [3:0] be);
    logic [15:0] r;
    r[15:8] = be[3] ? data[31:24] : 8'h00;
    r[7:0] = be[2] ? data[23:16] : 8'h00;
    return r;
  endfunction : statusLanes

  // Register writes; fixed bytes 0Eh, 0Fh, 14h simply have no storage
  always_comb
  begin
    logic [31:0] w;
    w = 32'h0000_0000;
    next_latReg = latReg;
    next_baseReg = baseReg;
    if (cfgWrite && hitsDword(cfgAddr, `CBH_OFS_LAT))
    begin
      // Fixed bytes share this dword; only lane 1 lands in storage
      w = mergeBytes({8'h00, 8'h00, latReg, 8'h00}, cfgWdata, cfgByteEn);
      next_latReg = w[15:8];
    end
    if (cfgWrite && hitsDword(cfgAddr, `CBH_OFS_BASE))
    begin
      // Low twelve bits are masked so the window always sits on a 4K boundary
      next_baseReg = mergeBytes(baseReg, cfgWdata, cfgByteEn) & `CBH_BASE_MASK;
    end
  end

  // Latency and base storage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latReg <= `CBH_RST_LAT;
      baseReg <= `CBH_RST_BASE;
    end
    else
    begin
      latReg <= next_latReg;
      baseReg <= next_baseReg;
    end
  end

  // Card-side status: hardware set wins over a write-one clear in the same cycle
  always_comb
  begin
    setBits = 16'h0000;
    setBits[`CBH_BIT_PARITY] = cardEvents.parityErr;
    setBits[`CBH_BIT_SERR] = cardEvents.systemErr;
    setBits[`CBH_BIT_MABORT] = cardEvents.masterAbort;
    setBits[`CBH_BIT_TABORT_RX] = cardEvents.targetAbortRx;
    setBits[`CBH_BIT_TABORT_TX] = cardEvents.targetAbortTx;
    setBits[`CBH_BIT_DPAR] = cardEvents.dataParity && cardEvents.wasMaster
                             && parityResponseEn;
    clrBits = 16'h0000;
    if (cfgWrite && hitsDword(cfgAddr, `CBH_OFS_STAT))
    begin
      clrBits = statusLanes(cfgWdata, cfgByteEn) & `CBH_STAT_CLR_MASK;
    end
    next_statReg = ((statReg & ~clrBits) | setBits) & `CBH_STAT_CLR_MASK;
    next_statReg = next_statReg | `CBH_STAT_RO_VALUE;
  end

  // Status storage; read-only bits are rebuilt every cycle and never stored apart
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      statReg <= `CBH_RST_STAT;
    end
    else
    begin
      statReg <= next_statReg;
    end
  end

  // Latency timer: one count per clock while this function is initiator
  always_comb
  begin
    next_ltState = ltState;
    next_latCnt = latCnt;
    next_latencyStop = 1'b0;
    unique case (ltState)
      CBH_LT_IDLE:
      begin
        // Idle holds the count at zero so each tenure is timed afresh
        next_latCnt = 8'h00;
        if (frameStart)
        begin
          next_ltState = CBH_LT_RUN;
          next_latCnt = 8'h00;
        end
      end
      CBH_LT_RUN:
      begin
        if (tenureEnd)
        begin
          next_ltState = CBH_LT_IDLE;
          next_latCnt = 8'h00;
        end
        else
        begin
          // Count saturates at the limit so a long grant cannot wrap it back below
          if (!latencyExpired(latCnt, latReg))
          begin
            next_latCnt = latCnt + 8'h01;
          end
          // Expired and grant removed: ask the initiator to finish
          next_latencyStop = latencyExpired(latCnt, latReg) && gntIn_n;
        end
      end
    endcase
  end

  // Timer registers; the stop request leaves a flip-flop, free of decode glitches
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ltState <= CBH_LT_IDLE;
      latCnt <= 8'h00;
      latencyStopQ <= 1'b0;
    end
    else
    begin
      ltState <= next_ltState;
      latCnt <= next_latCnt;
      latencyStopQ <= next_latencyStop;
    end
  end

  // Read mux; reads carry no side effects, so data is registered one cycle later
  always_comb
  begin
    next_rdata = rdataQ;
    next_ext = 1'b0;
    if (cfgRead)
    begin
      // Unmapped dwords below 80h fall through and read zero
      next_rdata = 32'h0000_0000;
      // Extension data is supplied elsewhere; only the select is raised here
      if (cfgAddr >= `CBH_EXT_START)
      begin
        next_ext = 1'b1;
      end
      else if (hitsDword(cfgAddr, `CBH_OFS_LAT))
      begin
        next_rdata = {`CBH_SELFTEST_CODE, `CBH_HDR_CODE, latReg, 8'h00};
      end
      else if (hitsDword(cfgAddr, `CBH_OFS_BASE))
      begin
        next_rdata = baseReg;
      end
      else if (hitsDword(cfgAddr, `CBH_OFS_CAP))
      begin
        next_rdata = {statReg, 8'h00, `CBH_CAP_CODE};
      end
    end
  end

  // Memory window decode: 4K window, legacy set in the upper half
  always_comb
  begin
    next_win = CBH_WIN_NONE;
    next_winOfs = 12'h000;
    if (memValid && (memAddr[31:12] == baseReg[31:12]))
    begin
      // Offsets from 800h up belong to the legacy register set
      next_winOfs = memAddr[11:0];
      next_win = (memAddr[11:0] >= `CBH_WIN_LEGACY) ? CBH_WIN_LEGACY : CBH_WIN_SOCKET;
    end
  end

  // Read answer registers; data holds until the next read strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdataQ <= 32'h0000_0000;
      extQ <= 1'b0;
    end
    else
    begin
      rdataQ <= next_rdata;
      extQ <= next_ext;
    end
  end

  // Window decode registers; a miss shows no window with offset zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      winQ <= CBH_WIN_NONE;
      winOfsQ <= 12'h000;
    end
    else
    begin
      winQ <= next_win;
      winOfsQ <= next_winOfs;
    end
  end

  // Outputs come straight from the registers above
  assign cfgRdata = rdataQ;
  assign cfgExtSelect = extQ;
  assign memWindow = winQ;
  assign memWinOffset = winOfsQ;
  assign latencyStop = latencyStopQ;
  assign socketWindowBase = baseReg;
  assign masterLatencyCount = latReg;
endmodule : cbh_config_header

// [dv/cbh_config_header_chk.sv]
// Port checker for the config header slice.
// Assumes one clock domain with an async active-low reset.
`timescale 1ns/1ps
module cbh_config_header_chk (
  input logic clk,
  input logic rst_n,
  input logic cfgRead,
  input logic [7:0] cfgAddr,
  input logic [31:0] cfgRdata,
  input logic cfgExtSelect,
  input logic frameStart,
  input logic tenureEnd,
  input logic gntIn_n,
  input logic latencyStop,
  input logic [31:0] socketWindowBase,
  input logic [7:0] masterLatencyCount
);
  import cbh_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Zero latency tenure with the grant withdrawn for three cycles
  sequence s_zeroRun;
    frameStart && masterLatencyCount == 8'h00 && gntIn_n && !tenureEnd
      ##1 (gntIn_n && !tenureEnd)[*2];
  endsequence
  a_zero_stop: assert property (s_zeroRun |-> latencyStop)
    else $error("no stop at zero latency");
  a_stop_gnt: assert property ($rose(latencyStop) |-> $past(gntIn_n))
    else $error("stop while granted");
  a_tenure_clears: assert property (tenureEnd |=> !latencyStop)
    else $error("stop kept after tenure");
  a_base_low: assert property (socketWindowBase[11:0] == 12'h000)
    else $error("base low bits set");
  a_fixed_codes: assert property (cfgRead && cfgAddr[7:2] == 6'h03
    |=> cfgRdata[31:16] == 16'h0082) else $error("bad fixed codes");
  a_lat_read: assert property (cfgRead && cfgAddr[7:2] == 6'h03
    |=> cfgRdata[15:8] == $past(masterLatencyCount)) else $error("bad latency read");
  a_cap_status: assert property (cfgRead && cfgAddr[7:2] == 6'h05
    |=> cfgRdata[7:0] == 8'ha0 && cfgRdata[26:25] == 2'b01) else $error("bad cap read");
  a_ext_flag: assert property (cfgRead |=> cfgExtSelect == $past(cfgAddr[7]))
    else $error("bad extension flag");
endmodule : cbh_config_header_chk
bind cbh_config_header cbh_config_header_chk chk (.clk, .rst_n, .cfgRead, .cfgAddr,
  .cfgRdata, .cfgExtSelect, .frameStart, .tenureEnd, .gntIn_n, .latencyStop,
  .socketWindowBase, .masterLatencyCount);

// [dv/cbh_host_model.sv]
// Host model issuing config cycles one at a time.
// Assumes its tasks are called after reset, from the clk domain.
`timescale 1ns/1ps
module cbh_host_model (
  input logic clk,
  output logic cfgWrite,
  output logic cfgRead,
  output logic [7:0] cfgAddr,
  output logic [31:0] cfgWdata,
  output logic [3:0] cfgByteEn,
  input logic [31:0] cfgRdata
);
  // Idle bus at time zero
  initial {cfgWrite, cfgRead, cfgAddr, cfgWdata, cfgByteEn} = '0;
  // Released address and data lines are inverted so stale values never look valid; byte enables keep their value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    cfgWrite <= 1'b1;
    cfgAddr <= a;
    cfgWdata <= d;
    cfgByteEn <= be;
    @(posedge clk);
    cfgWrite <= 1'b0;
    cfgAddr <= ~a;
    cfgWdata <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    cfgRead <= 1'b1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRead <= 1'b0;
    cfgAddr <= ~a;
    #1 d = cfgRdata;
  endtask : rd
endmodule : cbh_host_model

// [dv/cbh_config_header_bench.sv]
// Bench: host model on the config bus, card events and grant driven here.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
module cbh_config_header_bench;
  import cbh_pkg::*;
  logic clk, rst_n, cfgWrite, cfgRead, cfgExtSelect, memValid, frameStart, tenureEnd;
  logic gntIn_n, latencyStop, parityResponseEn;
  logic [7:0] cfgAddr, masterLatencyCount;
  logic [31:0] cfgWdata, cfgRdata, memAddr, socketWindowBase, rv;
  logic [3:0] cfgByteEn;
  logic [11:0] memWinOffset;
  cbh_win_e memWindow;
  cbh_events_s cardEvents;
  int mismatches, checked, n;
  cbh_host_model host (.clk, .cfgWrite, .cfgRead, .cfgAddr, .cfgWdata, .cfgByteEn, .cfgRdata);
  cbh_config_header dut (.clk, .rst_n, .cfgWrite, .cfgRead, .cfgAddr, .cfgWdata, .cfgByteEn,
    .cfgRdata, .cfgExtSelect, .memValid, .memAddr, .memWindow, .memWinOffset, .frameStart,
    .tenureEnd, .gntIn_n, .latencyStop, .parityResponseEn, .cardEvents, .socketWindowBase,
    .masterLatencyCount);
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // One event pulse; parity response enable is a level set alongside
  task automatic ev(input logic [6:0] v, input logic en);
    @(posedge clk);
    cardEvents <= cbh_events_s'(v);
    parityResponseEn <= en;
    @(posedge clk);
    cardEvents <= '0;
  endtask : ev
  task automatic st(input logic [15:0] e);
    host.rd(8'h14, rv);
    chk(rv[31:16], {16'h0, e});
  endtask : st
  task automatic start(input logic g);
    @(posedge clk);
    frameStart <= 1'b1;
    gntIn_n <= g;
    @(posedge clk);
    frameStart <= 1'b0;
    #1;
  endtask : start
  task automatic finish_tenure;
    @(posedge clk);
    tenureEnd <= 1'b1;
    @(posedge clk);
    tenureEnd <= 1'b0;
    #1 chk(latencyStop, 1'b0);
  endtask : finish_tenure
  // Reset values, fixed bytes, masked base bits and the extension flag
  task automatic t_regs;
    host.rd(8'h0c, rv);
    chk(rv & 32'hffff_ff00, 32'h0082_0000);
    host.wr(8'h0c, 32'hffff_5a00, 4'hf);
    chk(masterLatencyCount, 8'h5a);
    host.rd(8'h0c, rv);
    chk(rv & 32'hffff_ff00, 32'h0082_5a00);
    chk(socketWindowBase, 32'h0);
    host.wr(8'h10, 32'hffff_ffff, 4'hf);
    host.rd(8'h10, rv);
    chk(rv, 32'hffff_f000);
    host.wr(8'h14, 32'hffff_ffff, 4'hf);
    host.rd(8'h14, rv);
    chk(rv, 32'h0200_00a0);
    host.rd(8'h84, rv);
    chk({rv[31:1], cfgExtSelect}, 32'h1);
  endtask : t_regs
  // Each event sets its own flag; bit 8 needs all three conditions
  task automatic t_status;
    for (int i = 0; i < 5; i++)
    begin
      ev(7'h40 >> i, 1'b0);
      st(16'h0200 | (16'h8000 >> i));
      host.wr(8'h14, 32'hffff_0000, 4'hc);
      st(16'h0200);
    end
    ev(7'h03, 1'b0);
    st(16'h0200);
    ev(7'h02, 1'b1);
    st(16'h0200);
    ev(7'h03, 1'b1);
    st(16'h0300);
    // Zero keeps bit 8; a new event beats its own clear
    fork
      host.wr(8'h14, 32'h7eff_0000, 4'hc);
      ev(7'h10, 1'b1);
    join
    st(16'h2300);
  endtask : t_status
  // Expiry waits for the grant to go; every tenure is timed from zero
  task automatic t_latency;
    // Latency back to zero so the first tenure expires at once
    host.wr(8'h0c, 32'h0000_0000, 4'h2);
    start(1'b1);
    repeat (2) @(posedge clk);
    #1 chk(latencyStop, 1'b1);
    finish_tenure();
    host.wr(8'h0c, 32'h0000_0300, 4'h2);
    start(1'b0);
    repeat (8) @(posedge clk);
    #1 chk(latencyStop, 1'b0);
    @(posedge clk);
    gntIn_n <= 1'b1;
    @(posedge clk);
    #1 chk(latencyStop, 1'b1);
    finish_tenure();
    start(1'b1);
    for (n = 1; n < 9 && latencyStop !== 1'b1; n++)
      @(posedge clk) #1;
    chk(n, 5);
    if (n == 9)
      report_and_stop();
    finish_tenure();
  endtask : t_latency
  task automatic win(input logic [31:0] a, input cbh_win_e w, input logic [11:0] o);
    @(posedge clk);
    memValid <= 1'b1;
    memAddr <= a;
    @(posedge clk);
    #1 chk({memWindow, ((w == CBH_WIN_NONE) ? 12'h0 : memWinOffset)}, {w, o});
  endtask : win
  // Both halves of the window and a miss above it
  task automatic t_window;
    host.wr(8'h10, 32'h1234_5abc, 4'hf);
    chk(socketWindowBase, 32'h1234_5000);
    win(32'h1234_5804, CBH_WIN_LEGACY, 12'h804);
    win(32'h1234_57fc, CBH_WIN_SOCKET, 12'h7fc);
    win(32'h1234_6000, CBH_WIN_NONE, 12'h000);
  endtask : t_window
  // Main sequence
  initial
  begin
    {memValid, frameStart, tenureEnd, parityResponseEn, memAddr} = '0;
    {rst_n, gntIn_n, cardEvents} = {2'b01, 7'h00};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_status();
    t_latency();
    t_window();
    report_and_stop();
  end
endmodule : cbh_config_header_bench
